//--- core_seq_model.sv
// core sequencer model: turns an op code into request pulses
// assumes the bench changes the op just after a rising clock edge
module core_seq_model (
    input  wire logic [2:0] op_i,     // 1 call 2 irq 3 ret 4 retfie
    output logic            call_o,   // push
    output logic            irq_o,    // push and capture
    output logic            ret_o,    // pop
    output logic            retfie_o  // pop and restore
);
    timeunit 1ns;
    timeprecision 1ps;
    // one request per op, never two at once
    assign call_o   = op_i == 3'h1;
    assign irq_o    = op_i == 3'h2;
    assign ret_o    = op_i == 3'h3;
    assign retfie_o = op_i == 3'h4;
endmodule

//--- return_stack.sv
// return-address stack with overflow/underflow guard, context shadows and
// two file-select pointers; sits beside the core's program counter and
// sequencer, all on one processor clock with the system reset.
// assumes requests are single-cycle pulses from logic on the same clock
// Operation
// - A separate 16-entry stack of 15-bit words holds return addresses.
// - Pushing a full stack without a pop sets the overflow flag, popping empty without a push the underflow flag.
// - With stack-error reset enabled either error also raises a reset request.
// - Interrupt entry copies core registers into shadows and return from interrupt restores them.
// - Two independent file-select pointers each address program or data memory.
// - Each stack entry holds a full 15-bit program counter value.
module return_stack
    import rstack_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic                    CLOCK_I,        // processor clock
    input  wire logic                    RESETN_I,       // async reset, low
    input  wire logic                    CALL_I,         // subroutine call
    input  wire logic                    IRQ_ENTRY_I,    // interrupt entry
    input  wire logic                    RETURN_I,       // any return
    input  wire logic                    RETFIE_I,       // return from irq
    input  wire logic [PC_WIDTH-1:0]     RET_ADDR_I,     // address to push
    input  wire logic                    STK_RESET_EN_I, // stack error reset
    input  wire logic                    FLAG_CLEAR_I,   // clear both flags
    input  wire logic [CORE_WIDTH-1:0]   CORE_REGS_I [SHADOW_COUNT], // live
    input  wire logic                    FSP_WR_I,       // pointer write
    input  wire logic                    FSP_SEL_I,      // pointer 0 or 1
    input  wire logic [FSP_WIDTH-1:0]    FSP_DATA_I,     // pointer value
    output logic [PC_WIDTH-1:0]          TOP_ADDR_O,     // popped address
    output logic                         TOP_VALID_O,    // pop had an entry
    output logic                         OVERFLOW_O,     // overflow flag
    output logic                         UNDERFLOW_O,    // underflow flag
    output logic                         SOFT_RESET_O,   // reset request
    output logic                         RESTORE_O,      // shadow restore
    output logic [CORE_WIDTH-1:0]        SHADOW_O [SHADOW_COUNT], // saved
    output logic [FSP_WIDTH-1:0]         FSP0_O,         // pointer 0
    output logic [FSP_WIDTH-1:0]         FSP1_O,         // pointer 1
    output logic                         FSP0_PMEM_O,    // pointer 0 in pmem
    output logic                         FSP1_PMEM_O     // pointer 1 in pmem
);

    logic [PC_WIDTH-1:0]  stack_mem [DEPTH];
    logic [PTR_WIDTH:0]   count_reg, count_next;
    logic [PC_WIDTH-1:0]  top_reg, top_next;
    logic                 top_valid_reg, top_valid_next;
    logic                 ovf_reg, ovf_next;
    logic                 unf_reg, unf_next;
    logic                 srst_reg, srst_next;
    logic                 restore_reg, restore_next;
    logic [CORE_WIDTH-1:0] shadow_reg [SHADOW_COUNT];
    logic [CORE_WIDTH-1:0] shadow_next [SHADOW_COUNT];
    logic [FSP_WIDTH-1:0] fsp0_reg, fsp0_next;
    logic [FSP_WIDTH-1:0] fsp1_reg, fsp1_next;
    logic [PC_WIDTH-1:0]  mem_wr_data;
    logic [PTR_WIDTH-1:0] mem_wr_idx;
    logic                 mem_wr_en;
    logic                 push;
    logic                 pop;
    logic                 full;
    logic                 empty;
    logic                 ovf_ev;
    logic                 unf_ev;
    logic [PTR_WIDTH-1:0] wr_idx;
    logic [PTR_WIDTH-1:0] rd_idx;

    assign push   = CALL_I | IRQ_ENTRY_I;
    assign pop    = RETURN_I | RETFIE_I;
    // count is one bit wider than an index so full and empty differ
    assign full   = (count_reg == (PTR_WIDTH+1)'(DEPTH));
    assign empty  = (count_reg == COUNT_RESET);
    assign wr_idx = count_reg[PTR_WIDTH-1:0];
    assign rd_idx = PTR_WIDTH'(count_reg - 5'h01);
    // simultaneous push and pop replaces the top entry, or is a plain push on an empty stack
    assign ovf_ev = push & ~pop & full;
    assign unf_ev = pop & ~push & empty;

    always_comb begin
        count_next     = count_reg;
        top_next       = top_reg;
        top_valid_next = 1'b0;
        if (pop && !empty) begin
            top_next       = stack_mem[rd_idx];
            top_valid_next = 1'b1;
            if (!push) begin
                count_next = count_reg - 5'h01;
            end
        end else if (push && !full) begin
            count_next = count_reg + 5'h01;
        end
    end

    // a pop on an empty stack leaves the last popped address in place
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            count_reg     <= COUNT_RESET;
            top_reg       <= PC_RESET;
            top_valid_reg <= 1'b0;
        end else begin
            count_reg     <= count_next;
            top_reg       <= top_next;
            top_valid_reg <= top_valid_next;
        end
    end

    // write port: a replace reuses the top slot; a push beside a pop
    // on an empty stack is a plain push, so the entry is never lost
    always_comb begin
        mem_wr_en   = 1'b0;
        mem_wr_idx  = wr_idx;
        mem_wr_data = RET_ADDR_I;
        if (push && pop && !empty) begin
            mem_wr_en  = 1'b1;
            mem_wr_idx = rd_idx;
        end else if (push && !full) begin
            mem_wr_en  = 1'b1;
        end
    end

    // stack storage has no reset: entries above the pointer are never read
    always_ff @(posedge CLOCK_I) begin
        if (mem_wr_en) begin
            stack_mem[mem_wr_idx] <= mem_wr_data;
        end
    end

    always_comb begin
        ovf_next     = ovf_reg;
        unf_next     = unf_reg;
        if (FLAG_CLEAR_I) begin
            ovf_next = 1'b0;
            unf_next = 1'b0;
        end
        if (ovf_ev) begin
            ovf_next = 1'b1;
        end
        if (unf_ev) begin
            unf_next = 1'b1;
        end
        // error reset request; only a pulse, this block keeps running
        srst_next    = STK_RESET_EN_I & (ovf_ev | unf_ev);
        // restore strobe; the core copies the shadows back on it
        restore_next = RETFIE_I;
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ovf_reg     <= 1'b0;
            unf_reg     <= 1'b0;
            srst_reg    <= 1'b0;
            restore_reg <= 1'b0;
        end else begin
            ovf_reg     <= ovf_next;
            unf_reg     <= unf_next;
            srst_reg    <= srst_next;
            restore_reg <= restore_next;
        end
    end

    // independent pointers, written one at a time
    always_comb begin
        fsp0_next = fsp0_reg;
        fsp1_next = fsp1_reg;
        if (FSP_WR_I && !FSP_SEL_I) begin
            fsp0_next = FSP_DATA_I;
        end
        if (FSP_WR_I && FSP_SEL_I) begin
            fsp1_next = FSP_DATA_I;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            fsp0_reg <= FSP_RESET;
            fsp1_reg <= FSP_RESET;
        end else begin
            fsp0_reg <= fsp0_next;
            fsp1_reg <= fsp1_next;
        end
    end

    // shadow capture on entry
    // only the latest entry is kept: a nested entry overwrites the copies
    genvar g;
    generate
        for (g = 0; g < SHADOW_COUNT; g++) begin : g_shadow
            always_comb begin
                shadow_next[g] = shadow_reg[g];
                if (IRQ_ENTRY_I) begin
                    shadow_next[g] = CORE_REGS_I[g];
                end
            end
            always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
                if (!RESETN_I) begin
                    shadow_reg[g] <= 8'h00;
                end else begin
                    shadow_reg[g] <= shadow_next[g];
                end
            end
            assign SHADOW_O[g] = shadow_reg[g];
        end
    endgenerate

    assign TOP_ADDR_O   = top_reg;
    assign TOP_VALID_O  = top_valid_reg;
    assign OVERFLOW_O   = ovf_reg;
    assign UNDERFLOW_O  = unf_reg;
    assign SOFT_RESET_O = srst_reg;
    assign RESTORE_O    = restore_reg;
    assign FSP0_O       = fsp0_reg;
    assign FSP1_O       = fsp1_reg;
    assign FSP0_PMEM_O  = fsp0_reg[PMEM_SEL_BIT];
    assign FSP1_PMEM_O  = fsp1_reg[PMEM_SEL_BIT];

endmodule

//--- return_stack_monitor.sv
// assertion checker bound to the return-address stack top
// assumes one clock domain and the active-low async reset
module return_stack_monitor
    import rstack_pkg::*;
#(parameter int DEPTH = STACK_DEPTH) (
    input wire logic CLOCK_I, RESETN_I, CALL_I, IRQ_ENTRY_I, // requests
    input wire logic RETURN_I, RETFIE_I, STK_RESET_EN_I,     // requests
    input wire logic FLAG_CLEAR_I, FSP_WR_I, FSP_SEL_I,      // controls
    input wire logic [FSP_WIDTH-1:0] FSP_DATA_I, FSP0_O, FSP1_O, // ptrs
    input wire logic TOP_VALID_O, OVERFLOW_O, UNDERFLOW_O,   // status
    input wire logic SOFT_RESET_O, RESTORE_O,                // pulses
    input wire logic FSP0_PMEM_O, FSP1_PMEM_O                // space
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    sequence err_rise;
        $rose(OVERFLOW_O) || $rose(UNDERFLOW_O);
    endsequence
    chk_ovf_cause: assert property (
        $rose(OVERFLOW_O) |-> $past(CALL_I || IRQ_ENTRY_I))
        else $error("overflow without a push");
    chk_unf_cause: assert property (
        $rose(UNDERFLOW_O) |-> $past(RETURN_I || RETFIE_I))
        else $error("underflow without a pop");
    chk_flag_sticky: assert property (
        OVERFLOW_O && !FLAG_CLEAR_I |=> OVERFLOW_O)
        else $error("overflow flag dropped");
    chk_soft_reset: assert property (
        err_rise |-> SOFT_RESET_O == $past(STK_RESET_EN_I))
        else $error("reset request wrong on stack error");
    chk_restore_pulse: assert property (
        RETFIE_I |=> RESTORE_O)
        else $error("no restore after irq return");
    chk_valid_cause: assert property (
        TOP_VALID_O |-> $past(RETURN_I || RETFIE_I))
        else $error("valid without a pop");
    chk_fsp_write: assert property (
        FSP_WR_I && !FSP_SEL_I |=> FSP0_O == $past(FSP_DATA_I))
        else $error("pointer 0 write lost");
    chk_pmem_bits: assert property (
        FSP_WR_I |=> $past(FSP_DATA_I[PMEM_SEL_BIT])
        == ($past(FSP_SEL_I) ? FSP1_PMEM_O : FSP0_PMEM_O))
        else $error("memory select bit mismatch");
endmodule
bind return_stack return_stack_monitor #(.DEPTH(DEPTH)) mon_u (.CLOCK_I,
    .RESETN_I, .CALL_I, .IRQ_ENTRY_I, .RETURN_I, .RETFIE_I, .FSP0_O,
    .STK_RESET_EN_I, .FLAG_CLEAR_I, .FSP_WR_I, .FSP_SEL_I, .FSP_DATA_I,
    .FSP1_O, .TOP_VALID_O, .OVERFLOW_O, .UNDERFLOW_O, .SOFT_RESET_O,
    .RESTORE_O, .FSP0_PMEM_O, .FSP1_PMEM_O);

//--- return_stack_tb_top.sv
// self-checking bench for the return-address stack
// assumes answers land one clock after the request edge
module return_stack_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rstack_pkg::*;
    logic clk = 0, rstn = 0, en = 1, clr = 0, wr = 0, sel = 0;
    logic call, irq, ret, rfi, vld, ovf, unf, srst, rsto, p0, p1;
    logic [2:0] op = 0;
    logic [14:0] addr = 0, top;
    logic [15:0] fd = 0, f0, f1;
    logic [7:0] regs [SHADOW_COUNT] = '{default: 8'h00};
    logic [7:0] shd [SHADOW_COUNT];
    int n_errors = 0, num_checks = 0, cyc = 0;
    core_seq_model core_u (.op_i(op), .call_o(call), .irq_o(irq),
        .ret_o(ret), .retfie_o(rfi));
    return_stack dut_u (.CLOCK_I(clk), .RESETN_I(rstn), .CALL_I(call),
        .IRQ_ENTRY_I(irq), .RETURN_I(ret), .RETFIE_I(rfi),
        .RET_ADDR_I(addr), .STK_RESET_EN_I(en), .FLAG_CLEAR_I(clr),
        .CORE_REGS_I(regs), .FSP_WR_I(wr), .FSP_SEL_I(sel),
        .FSP_DATA_I(fd), .TOP_ADDR_O(top), .TOP_VALID_O(vld),
        .OVERFLOW_O(ovf), .UNDERFLOW_O(unf), .SOFT_RESET_O(srst),
        .RESTORE_O(rsto), .SHADOW_O(shd), .FSP0_O(f0), .FSP1_O(f1),
        .FSP0_PMEM_O(p0), .FSP1_PMEM_O(p1));
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (++cyc > 3000) begin
        n_errors++;
        end_sim();
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // op stays up until the next call replaces it, so back-to-back calls
    // never drive it twice in one time step
    task step(input logic [2:0] o, input logic [14:0] a);
        op = o;
        addr = a;
        @(posedge clk);
        #1;
    endtask
    task t_fill;
        for (int i = 0; i < 16; i++) step(1, 15'(i * 2049 + 1));
        chk("ovf", 0, ovf);
        step(1, 15'h7FFF);
        chk("ovf", 1, ovf);
        chk("srst", 1, srst);
        for (int i = 15; i >= 0; i--) begin
            step(3, 0);
            chk("top", 16'(i * 2049 + 1), 16'(top));
            chk("vld", 1, vld);
        end
        step(4, 0);
        chk("unf", 1, unf);
        chk("vld", 0, vld);
        $display("fill test done");
    endtask
    task t_clear;
        en = 0;
        clr = 1;
        step(0, 0);
        clr = 0;
        chk("ovf", 0, ovf);
        step(3, 0);
        chk("unf", 1, unf);
        chk("srst", 0, srst);
        clr = 1;
        step(3, 0);
        clr = 0;
        chk("unf", 1, unf);
        $display("clear test done");
    endtask
    task t_irq;
        foreach (regs[k]) regs[k] = 8'hA0 + 8'(k);
        step(2, 15'h1234);
        foreach (shd[k]) chk("shd", 16'hA0 + 16'(k), 16'(shd[k]));
        step(4, 0);
        chk("rsto", 1, rsto);
        chk("top", 16'h1234, 16'(top));
        $display("irq test done");
    endtask
    task t_fsp;
        {wr, sel, fd} = {2'b11, 16'h8123};
        step(0, 0);
        {sel, fd} = {1'b0, 16'h0456};
        step(0, 0);
        wr = 0;
        chk("fsp", 16'h8123, f1);
        chk("fsp", 16'h0456, f0);
        chk("pmem", 16'h2, 16'({p1, p0}));
        $display("pointer test done");
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rstn = 1;
        t_fill();
        t_clear();
        t_irq();
        t_fsp();
        end_sim();
    end
endmodule

//--- rstack_pkg.sv
// package for the return-address stack block: widths, depths, reset values
// assumes a single processor clock domain and active-low async reset
package rstack_pkg;
    localparam int PC_WIDTH      = 15;
    localparam int STACK_DEPTH   = 16;
    localparam int PTR_WIDTH     = 4;
    localparam int CORE_WIDTH    = 8;
    localparam int FSP_WIDTH     = 16;
    localparam int SHADOW_COUNT  = 5;
    localparam logic [PTR_WIDTH-1:0] PTR_RESET = 4'h0;
    localparam logic [PTR_WIDTH:0]   COUNT_RESET = 5'h00;
    localparam logic [PC_WIDTH-1:0]  PC_RESET = 15'h0000;
    localparam logic [FSP_WIDTH-1:0] FSP_RESET = 16'h0000;
    localparam int PMEM_SEL_BIT  = 15;
endpackage
